// ===== src/dpfrc_top.sv
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
module dpfrc_top (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // register bus
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic [31:0]                    prdata,
  // fast bus
  input  wire dpfrc_pkg::dpfrc_hs_req_type hs_in,
  output dpfrc_pkg::dpfrc_hs_rsp_type    hs_out,
  // flash read ports
  output dpfrc_pkg::dpfrc_rport_type     rport [2],
  input  wire logic [31:0]               rport_data [2],
  // programming engine
  output dpfrc_pkg::dpfrc_nvm_type       nvm_out,
  input  wire logic                      nvm_done,
  input  wire logic [6:0]                nvm_pb_index,
  output logic [31:0]                    nvm_pb_data,
  // chip erase, security, power, interrupt
  output logic                           vol_erase_req,
  input  wire logic                      vol_erase_done,
  output logic                           security_bit,
  input  wire logic                      sleep_req,
  output logic                           flash_powerdown,
  output logic                           done_irq
);

  typedef enum {C_IDLE, C_START, C_RUN, C_VOLER, C_EA, C_PAGE_AND, C_DONE} dpfrc_state_type;

  dpfrc_state_type              cstate;
  logic [31:0]                  pbuf [dpfrc_pkg::PAGE_WORDS];
  logic                         ready_int_en;
  logic                         read_wait_state_select;
  logic                         command_ready_flag;
  logic                         bad_command_flag;
  logic                         lock_err_flag;
  logic                         page_and_result;
  logic [15:0]                  lock_bits;
  logic [5:0]                   cmd_code;
  logic [dpfrc_pkg::PAGE_BITS-1:0] cmd_page;
  logic [6:0]                   and_idx;
  logic                         and_acc;
  logic                         rd_active;
  logic [21:0]                  cur_addr;
  logic [7:0]                   remain;
  logic [21:0]                  port_addr [2];
  logic [1:0]                   port_age [2];
  logic                         port_on [2];

  // ==========================================================================
  // register bus decode
  wire        apb_setup   = psel & ~penable;
  wire        apb_done    = psel & penable & pready;
  wire        sel_ctrl    = paddr == dpfrc_pkg::OFF_CTRL;
  wire        sel_cmd     = paddr == dpfrc_pkg::OFF_CMD;
  wire        sel_status  = paddr == dpfrc_pkg::OFF_STATUS;
  wire        mapped      = sel_ctrl | sel_cmd | sel_status;
  wire        ctrl_write  = apb_done & pwrite & sel_ctrl;
  wire        cmd_write   = apb_done & pwrite & sel_cmd;
  wire        status_read = apb_done & ~pwrite & sel_status;
  wire        busy        = cstate != C_IDLE;
  wire [7:0]  wr_key      = pwdata[dpfrc_pkg::CMD_KEY_LSB +: 8];
  wire [5:0]  wr_code     = pwdata[5:0];
  wire        code_ok     = (wr_code >= dpfrc_pkg::CMD_WRITE_PAGE)
                          & (wr_code <= dpfrc_pkg::CMD_SET_SECURE);
  wire        bad_set     = cmd_write & (busy | (wr_key != dpfrc_pkg::CMD_KEY) | ~code_ok);
  wire        cmd_accept  = cmd_write & ~bad_set;
  wire [31:0] ctrl_val    = {25'h0000000, read_wait_state_select, 5'h00, ready_int_en};
  wire [31:0] cmd_val     = {15'h0000, cmd_page, 2'h0, cmd_code};
  wire [31:0] status_val  = {lock_bits, 10'h000, page_and_result, security_bit,
                             bad_command_flag, lock_err_flag, 1'b0, command_ready_flag};
  wire [31:0] rd_mux      = sel_ctrl ? ctrl_val : sel_cmd ? cmd_val :
                            sel_status ? status_val : 32'h0000_0000;

  // zero-wait answer: pready is registered from the setup cycle, so access ends in the first enable cycle
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~mapped;
      prdata  <= (apb_setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ready_int_en           <= dpfrc_pkg::CTRL_RESET[dpfrc_pkg::CTRL_RDY_IE_BIT];
      read_wait_state_select <= dpfrc_pkg::CTRL_RESET[dpfrc_pkg::CTRL_WS_BIT];
    end
    else if (ctrl_write)
    begin
      ready_int_en           <= pwdata[dpfrc_pkg::CTRL_RDY_IE_BIT];
      read_wait_state_select <= pwdata[dpfrc_pkg::CTRL_WS_BIT];
    end
  end

  // ==========================================================================
  // read engine shared by the fast bus and the page check
  wire        and_mode  = cstate == C_PAGE_AND;
  wire        ws        = read_wait_state_select;
  wire [21:0] eng_addr  = and_mode ? {1'b0, 5'h00, cmd_page, and_idx} : cur_addr;
  wire        eng_go    = and_mode | rd_active;
  wire        p         = eng_addr[0];
  wire        held      = port_on[p] & (port_addr[p] == eng_addr);
  wire        hit       = held & (port_age[p] >= {1'b0, ws});
  wire        serve     = eng_go & hit;
  wire        load      = eng_go & ~held;
  wire [31:0] eng_data  = rport_data[p];
  wire        word_ones = &eng_data;
  wire        flash_off = (cstate == C_RUN) | (cstate == C_VOLER) | (cstate == C_EA);
  // stale prefetches are dropped when timing changes or the array may change
  wire        port_kill = ctrl_write | flash_off | flash_powerdown;
  wire        take_ok   = hs_in.req & ~hs_out.ack & ~rd_active & ~busy & ~flash_powerdown;
  wire        take_rd   = take_ok & ~hs_in.write;
  wire        take_wr   = take_ok & hs_in.write;
  wire [21:0] hs_word   = hs_in.addr[23:2];   // user page is word bit 21
  wire [6:0]  hs_widx   = hs_word[6:0];

  // each port holds one word; it is valid once its age reaches the wait-state count
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (!resetn || port_kill)
      begin
        port_on[i]   <= 1'b0;
        port_age[i]  <= 2'h0;
        port_addr[i] <= 22'h000000;
      end
      else if (load && (p == 1'(i)))
      begin
        port_on[i]   <= 1'b1;
        port_age[i]  <= 2'h0;
        port_addr[i] <= eng_addr;
      end
      else if (load && ws)
      begin
        port_on[i]   <= 1'b1;
        port_age[i]  <= 2'h0;
        port_addr[i] <= eng_addr + 22'h000001;
      end
      else if (serve && (p == 1'(i)) && ws)
      begin
        port_age[i]  <= 2'h0;
        port_addr[i] <= eng_addr + 22'h000002;
      end
      else if (serve && (p == 1'(i)))
      begin
        port_on[i]   <= 1'b0;
      end
      else if (port_age[i] != 2'h3)
      begin
        port_age[i]  <= port_age[i] + 2'h1;
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      rport[i].en   = port_on[i];
      rport[i].addr = port_addr[i][21:1];
    end
  end

  // user page and main array share this path unchanged
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rd_active <= 1'b0;
      cur_addr  <= 22'h000000;
      remain    <= 8'h00;
      hs_out    <= '0;
    end
    else
    begin
      hs_out.ack <= 1'b0;
      if (take_rd)
      begin
        rd_active <= 1'b1;
        cur_addr  <= hs_word;
        remain    <= hs_in.burst ? hs_in.beats : 8'h00;
      end
      else if (take_wr)
      begin
        hs_out.ack <= 1'b1;
      end
      else if (serve && !and_mode)
      begin
        hs_out.ack   <= 1'b1;
        hs_out.rdata <= eng_data;
        cur_addr     <= cur_addr + 22'h000001;
        remain       <= remain - 8'h01;
        rd_active    <= remain != 8'h00;
      end
    end
  end

  // ==========================================================================
  // page buffer: writes can only clear bits
  wire pb_clear = (cstate == C_START) & ~rd_active & (cmd_code == dpfrc_pkg::CMD_CLEAR_PBUF);

  always_ff @(posedge clk)
  begin
    if (pb_clear)
      for (int j = 0; j < dpfrc_pkg::PAGE_WORDS; j++)
        pbuf[j] <= 32'hFFFF_FFFF;
    else if (take_wr)
      pbuf[hs_widx] <= pbuf[hs_widx] & hs_in.wdata;
    nvm_pb_data <= pbuf[nvm_pb_index];
  end

  // ==========================================================================
  // command sequencer
  wire       start_now  = (cstate == C_START) & ~rd_active;
  wire [3:0] region     = 4'(cmd_page >> dpfrc_pkg::REGION_SHIFT);
  wire       page_lock  = lock_bits[region];
  wire       is_page_op = (cmd_code == dpfrc_pkg::CMD_WRITE_PAGE)
                        | (cmd_code == dpfrc_pkg::CMD_ERASE_PAGE);
  wire       is_ea      = cmd_code == dpfrc_pkg::CMD_ERASE_ALL;
  wire       lock_set   = start_now & ((is_page_op & page_lock) | (is_ea & (|lock_bits)));
  wire       and_last   = and_mode & serve & (and_idx == dpfrc_pkg::LAST_WORD);
  wire       and_val    = and_acc & word_ones;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cstate             <= C_IDLE;
      command_ready_flag <= 1'b1;
      bad_command_flag   <= 1'b0;
      lock_err_flag      <= 1'b0;
      page_and_result    <= 1'b0;
      lock_bits          <= 16'h0000;
      cmd_code           <= 6'h00;
      cmd_page           <= '0;
      and_idx            <= 7'h00;
      and_acc            <= 1'b1;
      nvm_out            <= '0;
      vol_erase_req      <= 1'b0;
      security_bit       <= 1'b0;
      done_irq           <= 1'b0;
      flash_powerdown    <= 1'b0;
    end
    else
    begin
      nvm_out.start    <= 1'b0;
      done_irq         <= 1'b0;
      bad_command_flag <= bad_set | (bad_command_flag & ~status_read);
      lock_err_flag    <= lock_set | (lock_err_flag & ~status_read);
      flash_powerdown  <= sleep_req & (flash_powerdown | (~busy & ~rd_active));
      if (take_wr)
        cmd_page <= hs_word[dpfrc_pkg::WORD_BITS +: dpfrc_pkg::PAGE_BITS];
      case (cstate)
        C_IDLE:
        begin
          if (cmd_write && !busy)
          begin
            command_ready_flag <= 1'b0;
            cstate             <= cmd_accept ? C_START : C_DONE;
            if (cmd_accept)
            begin
              cmd_code <= wr_code;
              cmd_page <= pwdata[dpfrc_pkg::CMD_PAGE_LSB +: dpfrc_pkg::PAGE_BITS];
            end
          end
        end
        // a command waits for the fast bus to fall idle before it starts
        C_START:
        begin
          if (!rd_active)
          begin
            cstate      <= C_DONE;
            nvm_out.op  <= cmd_code;
            nvm_out.page <= cmd_page;
            case (cmd_code)
              dpfrc_pkg::CMD_LOCK:       lock_bits[region] <= 1'b1;
              dpfrc_pkg::CMD_UNLOCK:     lock_bits[region] <= 1'b0;
              dpfrc_pkg::CMD_SET_SECURE: security_bit      <= 1'b1;
              dpfrc_pkg::CMD_WRITE_PAGE, dpfrc_pkg::CMD_ERASE_PAGE:
              begin
                if (!page_lock)
                begin
                  nvm_out.start <= 1'b1;
                  cstate        <= C_RUN;
                end
              end
              dpfrc_pkg::CMD_WRITE_USER, dpfrc_pkg::CMD_ERASE_USER:
              begin
                nvm_out.start <= 1'b1;
                cstate        <= C_RUN;
              end
              dpfrc_pkg::CMD_ERASE_ALL:
              begin
                if (lock_bits == 16'h0000)
                begin
                  vol_erase_req <= 1'b1;
                  cstate        <= C_VOLER;
                end
              end
              dpfrc_pkg::CMD_PAGE_AND:
              begin
                and_idx <= 7'h00;
                and_acc <= 1'b1;
                cstate  <= C_PAGE_AND;
              end
              default: ;
            endcase
          end
        end
        C_RUN:
          if (nvm_done)
            cstate <= C_DONE;
        C_VOLER:
        begin
          if (vol_erase_done)
          begin
            vol_erase_req <= 1'b0;
            nvm_out.start <= 1'b1;                 // main array only
            cstate        <= C_EA;
          end
        end
        C_EA:
        begin
          if (nvm_done)
          begin
            security_bit <= 1'b0;
            cstate       <= C_DONE;
          end
        end
        C_PAGE_AND:
        begin
          if (serve)
          begin
            and_acc <= and_val;
            and_idx <= and_idx + 7'h01;
          end
          if (and_last)
          begin
            page_and_result <= and_val;
            cstate          <= C_DONE;
          end
        end
        C_DONE:
        begin
          command_ready_flag <= 1'b1;
          done_irq           <= ready_int_en & (cmd_code != dpfrc_pkg::CMD_PAGE_AND);
          cstate             <= C_IDLE;
        end
        default: cstate <= C_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_burst_step;
    serve && !and_mode && ws && remain != 8'h00 && !ctrl_write;
  endsequence
  sequence s_ea_go;
    cstate == C_START && !rd_active && is_ea && lock_bits == 16'h0000;
  endsequence

  property p_ready_clear;
    cmd_write && !busy |=> !command_ready_flag ##1 cstate != C_IDLE || command_ready_flag;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");

  property p_bad_key;
    cmd_write && wr_key != dpfrc_pkg::CMD_KEY |=> bad_command_flag && !nvm_out.start;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key not flagged");

  property p_bad_clear;
    status_read && !bad_set |=> !bad_command_flag;
  endproperty
  a_bad_clear: assert property (p_bad_clear) else $error("status read kept flag");

  property p_one_port;
    !ws |-> !(rport[0].en && rport[1].en);
  endproperty
  a_one_port: assert property (p_one_port) else $error("both ports on at 0ws");

  property p_burst_rate;
    s_burst_step |=> serve ##1 hs_out.ack;
  endproperty
  a_burst_rate: assert property (p_burst_rate) else $error("burst stalled");

  property p_both_ports;
    ws && load |=> rport[0].en && rport[1].en;
  endproperty
  a_both_ports: assert property (p_both_ports) else $error("second port idle at 1ws");

  property p_and_result;
    and_last |=> page_and_result == $past(and_val) && cstate == C_DONE;
  endproperty
  a_and_result: assert property (p_and_result) else $error("page check wrong");

  property p_ea_order;
    s_ea_go |=> vol_erase_req && security_bit == $past(security_bit) && !nvm_out.start;
  endproperty
  a_ea_order: assert property (p_ea_order) else $error("erase order wrong");

  property p_lock_block;
    start_now && is_page_op && page_lock |=> !nvm_out.start && lock_err_flag;
  endproperty
  a_lock_block: assert property (p_lock_block) else $error("locked page changed");

  property p_powerdown;
    flash_powerdown |=> !rport[0].en && !rport[1].en;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("port on in sleep");

endmodule : dpfrc_top

// ===== common/dpfrc_pkg.sv
package dpfrc_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CMD    = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;

  // ==========================================================================
  // field positions
  localparam int CTRL_RDY_IE_BIT = 0;
  localparam int CTRL_WS_BIT     = 6;
  localparam int CMD_KEY_LSB     = 24;
  localparam int CMD_PAGE_LSB    = 8;
  localparam int ST_LOCK_LSB     = 16;

  // ==========================================================================
  // reset values and key
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // key value is arbitrary
  localparam logic [7:0]  CMD_KEY    = 8'h5A;

  // ==========================================================================
  // flash geometry
  localparam int PAGE_WORDS   = 128;
  localparam int PAGE_BITS    = 9;
  localparam int WORD_BITS    = 7;
  localparam int REGIONS      = 16;
  localparam int REGION_SHIFT = 5;
  localparam int WADDR_W      = 22;
  localparam int USER_BIT     = 21;
  localparam logic [6:0] LAST_WORD = 7'h7F;

  typedef enum logic [5:0] {
    CMD_WRITE_PAGE  = 6'h01,
    CMD_ERASE_PAGE  = 6'h02,
    CMD_CLEAR_PBUF  = 6'h03,
    CMD_LOCK        = 6'h04,
    CMD_UNLOCK      = 6'h05,
    CMD_ERASE_ALL   = 6'h06,
    CMD_WRITE_USER  = 6'h07,
    CMD_ERASE_USER  = 6'h08,
    CMD_PAGE_AND    = 6'h09,
    CMD_SET_SECURE  = 6'h0A
  } dpfrc_cmd_type;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        burst;
    logic [7:0]  beats;
    logic [23:0] addr;
    logic [31:0] wdata;
  } dpfrc_hs_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } dpfrc_hs_rsp_type;

  typedef struct packed {
    logic        en;
    logic [20:0] addr;
  } dpfrc_rport_type;

  typedef struct packed {
    logic                 start;
    logic [5:0]           op;
    logic [PAGE_BITS-1:0] page;
  } dpfrc_nvm_type;

endpackage : dpfrc_pkg

// ===== test/dpfrc_flash_model.sv
`timescale 1ns/1ps
// ============================================================
// flash block with two read ports and a slow programming engine
module dpfrc_flash_model #(
  parameter int BUSY = 20
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // read ports
  input  wire dpfrc_pkg::dpfrc_rport_type rport [2],
  output logic [31:0]                     rport_data [2],
  // programming engine and chip erase
  input  wire dpfrc_pkg::dpfrc_nvm_type   nvm_out,
  output logic                            nvm_done,
  output logic [6:0]                      nvm_pb_index,
  input  wire logic                       vol_erase_req,
  output logic                            vol_erase_done
);
  logic [31:0] tick;
  logic [7:0]  ncnt;
  logic [2:0]  vcnt;
  // page 3 of the main array is erased, every other word is distinct
  function automatic logic [31:0] word_of(input logic [21:0] w);
    return (w[21:7] == 15'h3) ? 32'hFFFF_FFFF : {10'h0, w} ^ 32'h5A5A_0000;
  endfunction : word_of
  // an idle port shows a changing pattern, never its last word
  assign rport_data[0]  = rport[0].en ? word_of({rport[0].addr, 1'b0}) : tick;
  assign rport_data[1]  = rport[1].en ? word_of({rport[1].addr, 1'b1}) : ~tick;
  assign nvm_done       = (ncnt == 8'h01);
  assign nvm_pb_index   = ncnt[6:0];
  assign vol_erase_done = (vcnt == 3'h3);
  always_ff @(posedge clk)
  begin
    tick <= resetn ? tick + 32'h9E37_79B9 : 32'h0000_0000;
    if (!resetn)
      ncnt <= 8'h00;
    else if (nvm_out.start)
      ncnt <= 8'(BUSY);
    else if (ncnt != 8'h00)
      ncnt <= ncnt - 8'h01;
    if (!resetn || !vol_erase_req)
      vcnt <= 3'h0;
    else if (vcnt < 3'h4)
      vcnt <= vcnt + 3'h1;
  end
endmodule : dpfrc_flash_model

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  logic                        clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic                        sleep_req, flash_powerdown, done_irq, vol_erase_req;
  logic                        vol_erase_done, security_bit, nvm_done, vol_seen, vol_first;
  logic                        pb_next;
  logic [7:0]                  paddr;
  logic [31:0]                 pwdata, prdata, rd, st_or, first_st;
  logic [31:0]                 pb_data, pb_seen, d1, d2;
  logic [31:0]                 rport_data [2];
  logic [6:0]                  nvm_pb_index;
  dpfrc_pkg::dpfrc_hs_req_type hs_in;
  dpfrc_pkg::dpfrc_hs_rsp_type hs_out;
  dpfrc_pkg::dpfrc_rport_type  rport [2];
  dpfrc_pkg::dpfrc_nvm_type    nvm_out;
  int                          fails, n_compared, n_irq, n0, both_on, ws, gap, lat;

  dpfrc_top i_dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .hs_in, .hs_out, .rport, .rport_data, .nvm_out, .nvm_done,
    .nvm_pb_index, .nvm_pb_data(pb_data), .vol_erase_req, .vol_erase_done, .security_bit,
    .sleep_req, .flash_powerdown, .done_irq);
  dpfrc_flash_model i_flash (.clk, .resetn, .rport, .rport_data, .nvm_out, .nvm_done,
    .nvm_pb_index, .vol_erase_req, .vol_erase_done);

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (done_irq === 1'b1) n_irq++;
    if (rport[0].en === 1'b1 && rport[1].en === 1'b1) both_on++;
    if (vol_erase_done === 1'b1) vol_seen = 1'b1;
    if (nvm_out.start === 1'b1 && nvm_out.op == 6'h06) vol_first = vol_seen;
    // page buffer word 5 shows up one cycle after the engine asks for it
    if (pb_next === 1'b1) pb_seen = pb_data;
    pb_next = (nvm_pb_index == 7'h05);
  end

  function automatic logic [31:0] exp_word(input logic [21:0] w);
    return (w[21:7] == 15'h3) ? 32'hFFFF_FFFF : {10'h0, w} ^ 32'h5A5A_0000;
  endfunction : exp_word
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmd(input logic [5:0] code, input logic [8:0] page, input logic [7:0] key);
    apb(1'b1, dpfrc_pkg::OFF_CMD, {key, 7'h00, page, 2'b00, code});
  endtask : cmd
  // status reads clear the error flags, so every poll is ORed into st_or
  task automatic wait_ready;
    int n;
    st_or = 32'h0;
    for (n = 0; n == 0 || rd[0] !== 1'b1; n++)
    begin
      apb(1'b0, dpfrc_pkg::OFF_STATUS, 32'h0);
      st_or |= rd;
      if (n == 0) first_st = rd;
    end
  endtask : wait_ready
  task automatic hs_read(input logic [23:0] a, input logic [7:0] beats);
    int n, k, last;
    @(posedge clk);
    hs_in.req <= 1'b1;
    hs_in.write <= 1'b0;
    hs_in.burst <= (beats != 8'h00);
    hs_in.beats <= beats;
    hs_in.addr <= a;
    n = 0;
    k = 0;
    gap = 0;
    while (k <= beats)
    begin
      @(posedge clk);
      n++;
      if (hs_out.ack === 1'b1)
      begin
        if (k == 0) lat = n;
        if (k > 0 && n - last > gap) gap = n - last;
        chk(hs_out.rdata, exp_word(22'(a[23:2] + k)));
        last = n;
        k++;
      end
    end
    hs_in.req <= 1'b0;
  endtask : hs_read
  task automatic hs_write(input logic [23:0] a, input logic [31:0] d);
    @(posedge clk);
    hs_in.req <= 1'b1;
    hs_in.write <= 1'b1;
    hs_in.burst <= 1'b0;
    hs_in.beats <= 8'h00;
    hs_in.addr <= a;
    hs_in.wdata <= d;
    do
      @(posedge clk);
    while (hs_out.ack !== 1'b1);
    hs_in.req <= 1'b0;
    hs_in.write <= 1'b0;
  endtask : hs_write
  task automatic wait_pd(input logic v);
    int n;
    for (n = 0; n < 10 && flash_powerdown !== v; n++) @(posedge clk);
    chk(flash_powerdown, v);
  endtask : wait_pd
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish;
  end
  initial
  begin
    {resetn, psel, penable, pwrite, sleep_req} = 5'h0;
    {paddr, pwdata, hs_in} = '0;
    {fails, n_compared, n_irq, both_on} = '0;
    {vol_seen, vol_first} = 2'b00;
    void'($urandom(50666));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, dpfrc_pkg::OFF_CTRL, 32'h0);
    chk(rd, dpfrc_pkg::CTRL_RESET);
    apb(1'b0, dpfrc_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("test registers done");
    for (ws = 0; ws < 2; ws++)
    begin
      apb(1'b1, dpfrc_pkg::OFF_CTRL, {25'h0, ws[0], 6'h00});
      both_on = 0;
      hs_read({2'b00, 20'($urandom), 2'b00}, 8'h00);
      chk(lat, ws ? 5 : 4);
      hs_read({2'b00, 20'($urandom), 2'b00}, 8'h07);
      chk(gap, ws ? 1 : 2);
      hs_read({1'b1, 16'h0, 5'($urandom), 2'b00}, 8'h03);
      chk(both_on > 0, ws[0]);
      $display("test reads at %0d wait states done", ws);
    end
    apb(1'b1, dpfrc_pkg::OFF_CTRL, 32'h1);
    cmd(6'h01, 9'h010, ~dpfrc_pkg::CMD_KEY);
    wait_ready;
    chk(st_or[3], 1'b1);
    apb(1'b0, dpfrc_pkg::OFF_STATUS, 32'h0);
    chk(rd[3], 1'b0);
    cmd(6'h0B, 9'h010, dpfrc_pkg::CMD_KEY);
    wait_ready;
    chk(st_or[3], 1'b1);
    n0 = n_irq;
    cmd(6'h01, 9'h010, dpfrc_pkg::CMD_KEY);
    cmd(6'h02, 9'h010, dpfrc_pkg::CMD_KEY);
    wait_ready;
    chk({first_st[0], st_or[3]}, 2'b01);
    chk(n_irq - n0, 1);
    for (int p = 2; p < 4; p++)
    begin
      n0 = n_irq;
      cmd(6'h09, 9'(p), dpfrc_pkg::CMD_KEY);
      wait_ready;
      chk(rd[5], p == 3);
      chk(n_irq - n0, 0);
    end
    $display("test commands done");
    cmd(6'h04, 9'h0A0, dpfrc_pkg::CMD_KEY);
    wait_ready;
    chk(rd[31:16], 16'h0020);
    cmd(6'h01, 9'h0A0, dpfrc_pkg::CMD_KEY);
    wait_ready;
    chk(st_or[2], 1'b1);
    cmd(6'h06, 9'h000, dpfrc_pkg::CMD_KEY);
    wait_ready;
    chk(st_or[2], 1'b1);
    cmd(6'h05, 9'h0BF, dpfrc_pkg::CMD_KEY);
    wait_ready;
    chk(rd[31:16], 16'h0000);
    cmd(6'h03, 9'h000, dpfrc_pkg::CMD_KEY);
    wait_ready;
    d1 = $urandom;
    d2 = $urandom;
    hs_write(24'h002014, d1);
    hs_write(24'h002014, d2);
    cmd(6'h01, 9'h010, dpfrc_pkg::CMD_KEY);
    wait_ready;
    chk(pb_seen, d1 & d2);
    chk(st_or[3:2], 2'b00);
    $display("test page buffer done");
    cmd(6'h0A, 9'h000, dpfrc_pkg::CMD_KEY);
    wait_ready;
    chk({security_bit, rd[4]}, 2'b11);
    cmd(6'h06, 9'h000, dpfrc_pkg::CMD_KEY);
    wait_ready;
    chk({vol_first, security_bit}, 2'b10);
    $display("test locks and erase done");
    sleep_req <= 1'b1;
    wait_pd(1'b1);
    sleep_req <= 1'b0;
    wait_pd(1'b0);
    $display("test sleep done");
    tally_and_finish;
  end
endmodule : tb
